// ===== rtl/tsai_core.sv
// slot access synchronisation, transfer and overflow interrupts
`timescale 1ns/1ns

// Behaviour
// [RULE1] monitor enable makes even register capture slot 11
// [RULE2] software selects 08h upstream or 88h downstream
// [RULE3] software accesses data between xfer and overflow
// [RULE4] four xfer, four overflow flags, one status
// [RULE5] xfer raised two or one bit after slot
// [RULE6] one bit clock is two double-rate clocks
// [RULE7] overflow raised when ack misses deadline
// [RULE8] software acks one or zero bits early
// [RULE9] overflow tracks own or all enabled xfers
// [RULE10] mask bit suppresses its interrupt
// [RULE11] status read clears all flags
// [RULE12] slot select 0..11, port select chooses line
// [RULE13] bit clock is half the double-rate clock
// [RULE14] looped data leaves one frame after capture
// [RULE15] flags sticky until read, output shows pending
module tsai_core
    import tsai_pkg::*;
#(
    parameter int NCH = 4                                   // data registers
)(
    // clock and reset
    input  wire logic      i_mclk,
    input  wire logic      i_rstn,
    // register port
    input  wire tsai_req_t i_req,
    output logic [7:0]     o_rdata,
    // interrupt
    output logic           o_irq,
    // frame bus pins
    input  wire logic      i_double_rate_clock,
    input  wire logic      i_frame_sync,
    input  wire logic      i_upstream_line,
    input  wire logic      i_downstream_line,
    output logic           o_upstream_line,
    output logic           o_upstream_line_oe,
    output logic           o_downstream_line,
    output logic           o_downstream_line_oe
);

    // ****************************************************************
    // helpers
    // ****************************************************************

    // fold a clock index into one frame
    function automatic logic [7:0] tsai_wrap(input logic [9:0] v);
        logic [9:0] r;
        r = v;
        if (r >= {2'b00, FRAME_DCL})
        begin
            r = r - {2'b00, FRAME_DCL};
        end
        return r[7:0];
    endfunction

    // clock index of the transfer interrupt of a channel
    function automatic logic [7:0] tsai_xfer_at(input logic [7:0] sel);
        logic [9:0] lag;
        lag = sel[SEL_PORT] ? 10'(BIT_DCL) : 10'(2 * BIT_DCL);   // [RULE5] [RULE6]
        return tsai_wrap(10'({6'h00, sel[3:0]} * 10'(SLOT_DCL))
                         + 10'(SLOT_DCL) + lag);
    endfunction

    // clock index of the acknowledge deadline of a channel
    function automatic logic [7:0] tsai_ovf_at(input logic [7:0] sel);
        logic [9:0] lead;
        lead = sel[SEL_PORT] ? 10'h000 : 10'(BIT_DCL);           // [RULE8]
        return tsai_wrap(10'({6'h00, sel[3:0]} * 10'(SLOT_DCL))
                         + {2'b00, FRAME_DCL} - lead);
    endfunction

    // ****************************************************************
    // state
    // ****************************************************************
    tsai_state_t s_q;                                       // registered state
    tsai_state_t s_d;                                       // next state

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb
    begin
        logic       dcl_ok;                                 // clock stages agree
        logic       rise;                                   // clock rising
        logic       fall;                                   // clock falling
        logic [7:0] idx;                                    // index after rise
        logic [3:0] trk;                                    // tracked channels
        logic [3:0] tgt;                                    // input slot
        logic       bit_in;                                 // sampled line bit
        logic       ien;                                    // input capture enabled
        s_d    = s_q;
        dcl_ok = 1'b0;
        rise   = 1'b0;
        fall   = 1'b0;
        idx    = 8'h00;
        trk    = 4'h0;
        tgt    = 4'h0;
        bit_in = 1'b0;
        ien    = 1'b0;

        // pin synchronisers, three stages each
        s_d.dcl_s = {s_q.dcl_s[1:0], i_double_rate_clock};
        s_d.fsc_s = {s_q.fsc_s[1:0], i_frame_sync};
        s_d.up_s  = {s_q.up_s[1:0], i_upstream_line};
        s_d.dn_s  = {s_q.dn_s[1:0], i_downstream_line};

        // a level counts once stages two and three agree
        dcl_ok = (s_q.dcl_s[2] == s_q.dcl_s[1]);
        if (dcl_ok)
        begin
            s_d.dcl_f = s_q.dcl_s[2];
        end
        rise = dcl_ok && s_q.dcl_s[2] && !s_q.dcl_f;
        fall = dcl_ok && !s_q.dcl_s[2] && s_q.dcl_f;

        // frame start is remembered until the next clock rise
        if (s_q.fsc_s[2] == s_q.fsc_s[1])
        begin
            s_d.fsc_f = s_q.fsc_s[2];
            if (s_q.fsc_s[2] && !s_q.fsc_f)
            begin
                s_d.fsc_seen = 1'b1;
            end
        end

        // register writes
        if (i_req.wr)
        begin
            case (i_req.addr)
                ADR_DATA0, 4'h1, 4'h2, 4'h3:
                begin
                    s_d.data[i_req.addr[1:0]] = i_req.wdata;
                end
                ADR_SEL0, 4'h5, 4'h6, 4'h7:
                begin
                    s_d.sel[i_req.addr[1:0]] = i_req.wdata;   // [RULE12]
                end
                ADR_CTRL0, 4'h9:
                begin
                    s_d.ctrl[i_req.addr[0]] = i_req.wdata[4:0];
                end
                ADR_MASK:
                begin
                    s_d.mask = i_req.wdata;
                end
                ADR_ACK:
                begin
                    s_d.pend = s_q.pend & ~i_req.wdata[3:0];  // ack clears wait
                end
                default:
                begin
                end
            endcase
        end

        // register reads, data stand one cycle later
        s_d.rdata = 8'h00;
        if (i_req.rd)
        begin
            case (i_req.addr)
                ADR_DATA0, 4'h1, 4'h2, 4'h3:
                begin
                    s_d.rdata = s_q.data[i_req.addr[1:0]];
                end
                ADR_SEL0, 4'h5, 4'h6, 4'h7:
                begin
                    s_d.rdata = s_q.sel[i_req.addr[1:0]];
                end
                ADR_CTRL0, 4'h9:
                begin
                    s_d.rdata = {3'b000, s_q.ctrl[i_req.addr[0]]};
                end
                ADR_MASK:
                begin
                    s_d.rdata = s_q.mask;
                end
                ADR_STAT:
                begin
                    s_d.rdata = s_q.stat;
                    s_d.stat  = 8'h00;                      // [RULE11]
                end
                default:
                begin
                    s_d.rdata = 8'h00;                      // unmapped reads zero
                end
            endcase
        end

        // clock rise: advance frame position, interrupts, output bits
        if (rise)
        begin
            if (s_q.fsc_seen || s_q.dcnt == FRAME_DCL - 8'h01)
            begin
                idx = 8'h00;
            end
            else
            begin
                idx = s_q.dcnt + 8'h01;
            end
            s_d.dcnt     = idx;
            s_d.fsc_seen = 1'b0;

            // overflow deadlines first, so a same-index xfer starts anew
            for (int c = 0; c < NCH; c++)
            begin
                if (!s_q.mask[OVF_LSB + c] && idx == tsai_ovf_at(s_q.sel[c]))
                begin
                    // own xfer when unmasked, else every enabled one [RULE9]
                    trk = s_q.mask[c] ? ~s_q.mask[3:0] : 4'(1 << c);
                    if (|(s_d.pend & trk))
                    begin
                        s_d.stat[OVF_LSB + c] = 1'b1;       // [RULE7] [RULE4]
                    end
                    s_d.pend = s_d.pend & ~trk;
                end
            end

            // transfer interrupts, set wins over a read clear
            for (int c = 0; c < NCH; c++)
            begin
                if (!s_q.mask[c] && idx == tsai_xfer_at(s_q.sel[c]))
                begin
                    s_d.stat[c] = 1'b1;                     // [RULE5] [RULE10]
                    s_d.pend[c] = 1'b1;
                end
            end

            // drive outputs on the first clock of each bit [RULE13]
            if (!idx[0])
            begin
                s_d.up_oe = 1'b0;
                s_d.dn_oe = 1'b0;
                for (int c = 0; c < NCH; c++)
                begin
                    if (s_q.ctrl[c / 2][CTL_OUT0 + c % 2]
                        && idx[7:4] == s_q.sel[c][3:0])
                    begin
                        // data held from a past frame go out [RULE14]
                        if (s_q.sel[c][SEL_PORT])
                        begin
                            s_d.up_oe = 1'b1;
                            s_d.up_o  = s_q.data[c][3'h7 - idx[3:1]];
                        end
                        else
                        begin
                            s_d.dn_oe = 1'b1;
                            s_d.dn_o  = s_q.data[c][3'h7 - idx[3:1]];
                        end
                    end
                end
            end
        end

        // clock fall in the second half of a bit: sample inputs
        if (fall && s_q.dcnt[0])
        begin
            for (int c = 0; c < NCH; c++)
            begin
                tgt = s_q.sel[c][3:0];
                ien = s_q.ctrl[c / 2][CTL_IN0 + c % 2];
                if (c % 2 == 0 && s_q.ctrl[c / 2][CTL_TBM])
                begin
                    tgt = TBM_SLOT;                         // [RULE1]
                    ien = 1'b1;                             // monitor needs no input enable
                end
                // input comes from the line opposite the output [RULE12]
                bit_in = s_q.sel[c][SEL_PORT] ? s_q.dn_s[2] : s_q.up_s[2];
                if (ien && s_q.dcnt[7:4] == tgt)
                begin
                    s_d.shf[c] = {s_q.shf[c][6:0], bit_in};
                    if ({1'b0, s_q.dcnt[3:1]} == LAST_BIT)
                    begin
                        s_d.data[c] = {s_q.shf[c][6:0], bit_in};
                    end
                end
            end
        end

        // level output while an unmasked flag is pending [RULE15]
        s_d.irq = |(s_d.stat & ~s_d.mask);
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            s_q      <= '0;
            s_q.mask <= MASK_RST;
            s_q.sel  <= {NCH{SEL_RST}};
            s_q.ctrl <= {2{CTRL_RST}};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ****************************************************************
    // outputs straight from flops
    // ****************************************************************
    assign o_rdata              = s_q.rdata;
    assign o_irq                = s_q.irq;
    assign o_upstream_line      = s_q.up_o;
    assign o_upstream_line_oe   = s_q.up_oe;
    assign o_downstream_line    = s_q.dn_o;
    assign o_downstream_line_oe = s_q.dn_oe;

endmodule

// ===== rtl/tsai_pkg.sv
// package: constants, bus carrier and state type of the slot access interrupt block
package tsai_pkg;
    // ****************************************************************
    // frame timing in double-rate clock periods
    // ****************************************************************
    localparam int          BIT_DCL   = 2;                  // one bit clock
    localparam int          SLOT_BITS = 8;                  // bits per slot
    localparam int          NUM_SLOTS = 12;                 // slots per frame
    localparam int          SLOT_DCL  = BIT_DCL * SLOT_BITS;
    localparam logic [7:0]  FRAME_DCL = 8'(SLOT_DCL * NUM_SLOTS);
    localparam logic [3:0]  TBM_SLOT  = 4'hb;               // terminal bus slot
    localparam logic [3:0]  LAST_BIT  = 4'h7;               // last bit of a slot
    // ****************************************************************
    // register indices
    // ****************************************************************
    localparam logic [3:0]  ADR_DATA0 = 4'h0;               // data regs 0..3
    localparam logic [3:0]  ADR_SEL0  = 4'h4;               // port selects 0..3
    localparam logic [3:0]  ADR_CTRL0 = 4'h8;               // pair controls 0..1
    localparam logic [3:0]  ADR_MASK  = 4'ha;               // interrupt mask
    localparam logic [3:0]  ADR_ACK   = 4'hb;               // acknowledge (write)
    localparam logic [3:0]  ADR_STAT  = 4'hc;               // status (read clears)
    // ****************************************************************
    // field positions and reset values
    // ****************************************************************
    localparam int          SEL_PORT  = 7;                  // port select bit
    localparam int          CTL_IN0   = 0;                  // even input enable
    localparam int          CTL_OUT0  = 2;                  // even output enable
    localparam int          CTL_TBM   = 4;                  // monitor enable
    localparam int          OVF_LSB   = 4;                  // overflow bits 7:4
    localparam logic [7:0]  MASK_RST  = 8'hff;              // all masked
    localparam logic [7:0]  SEL_RST   = 8'h00;
    localparam logic [4:0]  CTRL_RST  = 5'h00;
    // ****************************************************************
    // register bus request
    // ****************************************************************
    typedef struct packed {
        logic [3:0] addr;                                   // register index
        logic [7:0] wdata;                                  // write data
        logic       wr;                                     // write strobe
        logic       rd;                                     // read strobe
    } tsai_req_t;
    // ****************************************************************
    // whole state of the block
    // ****************************************************************
    typedef struct packed {
        logic [2:0]      dcl_s;                             // clock synchroniser
        logic [2:0]      fsc_s;                             // frame synchroniser
        logic [2:0]      up_s;                              // upstream synchroniser
        logic [2:0]      dn_s;                              // downstream synchroniser
        logic            dcl_f;                             // filtered clock level
        logic            fsc_f;                             // filtered frame level
        logic            fsc_seen;                          // frame start pending
        logic [7:0]      dcnt;                              // clock index in frame
        logic [3:0][7:0] sel;                               // slot_port_select regs
        logic [3:0][7:0] data;                              // slot_data_reg regs
        logic [3:0][7:0] shf;                               // input shifters
        logic [1:0][4:0] ctrl;                              // pair_control_reg regs
        logic [7:0]      mask;                              // xfer_int_mask
        logic [7:0]      stat;                              // sticky status
        logic [3:0]      pend;                              // unacknowledged xfers
        logic [7:0]      rdata;                             // read data
        logic            irq;                               // interrupt level
        logic            up_o;                              // upstream drive value
        logic            up_oe;                             // upstream drive enable
        logic            dn_o;                              // downstream drive value
        logic            dn_oe;                             // downstream drive enable
    } tsai_state_t;
endpackage

// ===== testbench/tsai_core_assertions.sv
// checker: read data, interrupt and line drive timing at the ports
`timescale 1ns/1ns
module tsai_core_assertions
    import tsai_pkg::*;
(
    // clock and reset
    input wire logic       i_mclk,
    input wire logic       i_rstn,
    // register port and interrupt
    input wire tsai_req_t  i_req,
    input wire logic [7:0] o_rdata,
    input wire logic       o_irq,
    // frame bus pins
    input wire logic       i_double_rate_clock,
    input wire logic       o_upstream_line,
    input wire logic       o_upstream_line_oe,
    input wire logic       o_downstream_line,
    input wire logic       o_downstream_line_oe
);
    // ****
    // helper: clocks since pin rise, mask shadow
    // ****
    logic       dcl_p;                              // last pin sample
    logic [7:0] age;                                // saturating age
    logic [7:0] msk;                                // mask shadow
    logic       mwr;                                // mask write
    logic       srd;                                // status read
    assign mwr = i_req.wr && i_req.addr == ADR_MASK;
    assign srd = i_req.rd && i_req.addr == ADR_STAT;
    // track pin rises and mask writes
    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            dcl_p <= 1'b0;
            age   <= 8'hff;
            msk   <= MASK_RST;
        end
        else
        begin
            dcl_p <= i_double_rate_clock;
            age   <= (i_double_rate_clock && !dcl_p) ? 8'h00 : age + 8'(age != 8'hff);
            msk   <= mwr ? i_req.wdata : msk;
        end
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);
    // ****
    // properties
    // ****
    a_rdata_quiet: assert property (!i_req.rd |=> o_rdata == 8'h00)
        else $error("read data not zero outside a read");
    a_unmapped_zero: assert property (i_req.rd && (i_req.addr > ADR_STAT
        || i_req.addr == ADR_ACK) |=> o_rdata == 8'h00) else $error("unmapped read not zero");
    a_mask_readback: assert property (i_req.rd && i_req.addr == ADR_MASK |=> o_rdata == msk)
        else $error("mask readback wrong");
    a_mask_all_quiet: assert property (msk == 8'hff && $past(msk) == 8'hff |-> !o_irq)
        else $error("interrupt while all masked");
    a_irq_rise_cause: assert property ($rose(o_irq) |-> age <= 8'd10
        || $past(mwr) || $past(mwr, 2)) else $error("interrupt rose without cause");
    a_irq_read_drop: assert property (srd && age >= 8'd3 && age <= 8'd13 |-> ##2 !o_irq)
        else $error("interrupt stayed after status read");
    a_read_clears: assert property ((srd && age >= 8'd3 && age <= 8'd13) ##2 srd
        |=> o_rdata == 8'h00) else $error("status not cleared by read");
    a_up_line_timed: assert property ($changed({o_upstream_line, o_upstream_line_oe})
        |-> age <= 8'd8) else $error("up line changed off a clock rise");
    a_dn_line_timed: assert property ($changed({o_downstream_line, o_downstream_line_oe})
        |-> age <= 8'd8) else $error("down line changed off a clock rise");
endmodule

// ===== testbench/tsai_bus_model.sv
// partner: frame clock, frame marker and open-drain talker on both lines
`timescale 1ns/1ns
module tsai_bus_model #(
    parameter int HALF = 400                        // half clock period in ns
)(
    // level of the down wire
    input  wire logic        i_dn_wire,
    // pins towards the block
    output logic             o_dcl,
    output logic             o_fsc,
    output logic             o_up_drv,
    output logic             o_dn_drv,
    // frame position and bytes heard on the down line
    output logic [7:0]       o_idx,
    output logic [11:0][7:0] o_rx
);
    localparam logic [7:0] DN_TBM = 8'h5b;          // down byte in slot 11
    logic [7:0] ub;                                 // up byte of this slot
    logic [7:0] sh;                                 // down line shifter
    // free running clock, bytes out msb first
    initial
    begin
        o_dcl = 1'b0;
        o_fsc = 1'b0;
        o_up_drv = 1'b1;
        o_dn_drv = 1'b1;
        o_idx = 8'd100;
        o_rx = '0;
        sh = 8'h00;
        #137;
        forever
        begin
            #HALF o_dcl = 1'b1;
            o_idx = (o_idx == 8'd191) ? 8'd0 : o_idx + 8'd1;
            ub = {4'ha, o_idx[7:4]};
            // new bit on the first clock of each bit
            if (!o_idx[0])
            begin
                o_up_drv = ub[~o_idx[3:1]];
                o_dn_drv = (o_idx[7:4] == 4'hb) ? DN_TBM[~o_idx[3:1]] : 1'b1;
            end
            #HALF o_dcl = 1'b0;
            // sample on the fall of the second clock
            if (o_idx[0])
            begin
                sh = {sh[6:0], i_dn_wire};
                if (o_idx[3:0] == 4'hf)
                    o_rx[o_idx[7:4]] = sh;
            end
            // marker high just before index 0
            o_fsc = (o_idx == 8'd191);
        end
    end
endmodule

// ===== testbench/tsai_core_tb.sv
// testbench: registers, transfer and overflow timing, monitoring, looping
`timescale 1ns/1ns
module tsai_core_tb
    import tsai_pkg::*;
;
    logic             i_mclk, i_rstn, o_irq;        // clock, reset, interrupt
    tsai_req_t        req;                          // register request
    logic [7:0]       o_rdata, idx, ush;            // read data, frame index, up bits
    logic             double_rate_clock, frame_sync, up_drv, dn_drv;     // partner pins
    logic             up_o, up_oe, dn_o, dn_oe;     // block drive
    logic             up_w, dn_w, rd_due;           // wire levels, read flag
    logic [11:0][7:0] rx;                           // bytes on the down line
    logic [31:0]      seed;                         // random state
    logic [7:0]       sl [4];                       // chosen selects
    logic [7:0]       exq [$];                      // expected read data
    int               fails, checks;
    // open-drain wires with pull-up
    assign up_w = up_drv & (~up_oe | up_o);
    assign dn_w = dn_drv & (~dn_oe | dn_o);
    tsai_core #(.NCH(4)) u_dut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_req(req),
        .o_rdata(o_rdata), .o_irq(o_irq), .i_double_rate_clock(double_rate_clock), .i_frame_sync(frame_sync),
        .i_upstream_line(up_w), .i_downstream_line(dn_w), .o_upstream_line(up_o),
        .o_upstream_line_oe(up_oe), .o_downstream_line(dn_o), .o_downstream_line_oe(dn_oe));
    tsai_bus_model #(.HALF(400)) u_bus (.i_dn_wire(dn_w), .o_dcl(double_rate_clock), .o_fsc(frame_sync),
        .o_up_drv(up_drv), .o_dn_drv(dn_drv), .o_idx(idx), .o_rx(rx));
    // ****
    // helpers
    // ****
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // transfer index: two or one bit after the slot
    function automatic logic [7:0] xidx(input logic [7:0] s);
        return 8'((16 * s[3:0] + (s[7] ? 18 : 20)) % 192);
    endfunction
    // deadline index: one or zero bits before the slot
    function automatic logic [7:0] dlidx(input logic [7:0] s);
        return 8'((16 * s[3:0] + (s[7] ? 192 : 190)) % 192);
    endfunction
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_mclk);
        req <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b0};
    endtask
    // read and note the expected data
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge i_mclk);
        exq.push_back(e);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge i_mclk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
    endtask
    // wait for the interrupt, then check the frame index
    task automatic wait_irq(input logic [7:0] e);
        int n;
        n = 0;
        @(negedge i_mclk);
        while (o_irq !== 1'b1 && n < 4000)
        begin
            @(negedge i_mclk);
            n++;
        end
        chk("irq", 8'h01, {7'h0, o_irq});
        chk("index", e, idx);
    endtask
    // transfer on channel 0, then ack or overflow on channel oc
    task automatic ovf_case(input logic [7:0] m, input int oc, input logic ack,
                            input logic [7:0] e);
        wr(ADR_ACK, 8'h0f);
        rd(ADR_STAT, 8'h00);
        wr(ADR_MASK, m);
        wait_irq(xidx(sl[0]));
        rd(ADR_STAT, 8'h01);
        if (ack)
            wr(ADR_ACK, 8'h01);
        wait_irq(ack ? xidx(sl[0]) : dlidx(sl[oc]));
        rd(ADR_STAT, e);
        wr(ADR_MASK, 8'hff);
    endtask
    task automatic close_out();
        if (fails == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // ****
    // processes
    // ****
    initial
    begin
        i_mclk = 1'b0;
        forever #25 i_mclk = ~i_mclk;
    end
    // read result monitor, oldest note first
    always @(negedge i_mclk)
    begin
        if (rd_due)
            chk("rdata", exq.pop_front(), o_rdata);
        rd_due = req.rd;
    end
    // bits the block drives on the up line, taken where the partner samples
    always @(negedge double_rate_clock)
    begin
        if (idx[0] && up_oe)
            ush <= {ush[6:0], up_o};
    end
    initial
    begin
        repeat (90000) @(posedge i_mclk);
        fails++;
        close_out();
    end
    initial
    begin
        i_rstn = 1'b0;
        req = '0;
        rd_due = 1'b0;
        seed = 32'hce07;
        repeat (3) @(posedge i_mclk);
        i_rstn <= 1'b1;
        for (int a = 0; a < 16; a++)
            rd(4'(a), (a == 10) ? MASK_RST : 8'h00);
        for (int c = 0; c < 4; c++)
        begin
            seed = lfsr(seed);
            sl[c] = {seed[0], 3'h0, 4'(seed[7:4] % 12)};
            wr(ADR_SEL0 + 4'(c), sl[c]);
            rd(ADR_SEL0 + 4'(c), sl[c]);
        end
        wr(ADR_MASK, seed[23:16]);
        rd(ADR_MASK, seed[23:16]);
        wr(ADR_MASK, 8'hff);
        repeat (3200) @(posedge i_mclk);
        for (int c = 0; c < 4; c++)
        begin
            rd(ADR_STAT, 8'h00);
            wr(ADR_MASK, 8'(~(8'h01 << c)));
            wait_irq(xidx(sl[c]));
            rd(ADR_STAT, 8'(8'h01 << c));
            rd(ADR_STAT, 8'h00);
            wr(ADR_MASK, 8'hff);
        end
        ovf_case(8'hee, 0, 1'b0, 8'h10);
        ovf_case(8'hee, 0, 1'b1, 8'h01);
        ovf_case(8'hde, 1, 1'b0, 8'h20);
        repeat (3200) @(posedge i_mclk);
        chk("irq", 8'h00, {7'h0, o_irq});
        rd(ADR_STAT, 8'h00);
        wr(ADR_CTRL0, 8'h10);
        for (int k = 0; k < 2; k++)
        begin
            wr(ADR_SEL0, k ? 8'h88 : 8'h08);
            repeat (6400) @(posedge i_mclk);
            rd(ADR_DATA0, k ? 8'h5b : 8'hab);
        end
        wr(ADR_CTRL0, 8'h0f);
        wr(ADR_SEL0, 8'h03);
        wr(ADR_SEL0 + 4'h1, 8'h8b);
        repeat (9600) @(posedge i_mclk);
        chk("loop", 8'ha3, rx[3]);
        chk("up line", 8'h5b, ush);
        wr(ADR_MASK, 8'hfe);
        wait_irq(xidx(8'h03));
        rd(ADR_DATA0, 8'ha3);
        rd(ADR_STAT, 8'h01);
        repeat (2) @(posedge i_mclk);
        close_out();
    end
endmodule
bind tsai_core tsai_core_assertions u_chk (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_req(i_req),
    .o_rdata(o_rdata), .o_irq(o_irq), .i_double_rate_clock(i_double_rate_clock),
    .o_upstream_line(o_upstream_line), .o_upstream_line_oe(o_upstream_line_oe),
    .o_downstream_line(o_downstream_line), .o_downstream_line_oe(o_downstream_line_oe));
